// >>> rtl/octal_switch_map.svh
// constants: frame layout, diagnosis codes, reset values
`ifndef OCTAL_SWITCH_MAP_SVH
`define OCTAL_SWITCH_MAP_SVH

// frame: control byte then data byte, msb first
`define FRAME_BITS 5'h10
`define COUNT_MAX 5'h1F
`define CTRL_MSB 15
`define CTRL_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define CTRL_DIAG_ONLY 8'h00

// two bits per channel, high channel in the upper bits
`define CODE_OK 2'h3
`define CODE_OVERLOAD 2'h2
`define CODE_OPEN 2'h1
`define CODE_SHORT_GND 2'h0
`define DIAG_IDLE 16'hFFFF

`define CHANNELS 8
`define PAR_CHANNELS 4
`define CHAN_OFF 8'h00
`define PAR_OFF 4'h0
`define FAULT_NONE 8'h00

`endif

// >>> rtl/octal_switch_pkg.sv
// shared types and helper functions of the octal switch
package octal_switch_pkg;
  `include "octal_switch_map.svh"

  typedef logic [1:0] diag_code_type;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic rstp_s1;
    logic rstp_s2;
    logic psel_s1;
    logic psel_s2;
    logic [3:0] par_s1;
    logic [3:0] par_s2;
    logic [7:0] ovl_s1;
    logic [7:0] ovl_s2;
    logic [7:0] opn_s1;
    logic [7:0] opn_s2;
    logic [7:0] sgd_s1;
    logic [7:0] sgd_s2;
    logic [15:0] diag;
    logic [15:0] snap;
    logic frame_id;
    logic frame_open;
    logic [7:0] latch;
    logic [7:0] out;
    logic fault_oe;
    logic so_oe;
  } ctrl_state_type;

  typedef struct packed {
    logic seen_id;
    logic [4:0] count;
    logic [15:0] word;
  } rx_state_type;

  typedef struct packed {
    logic seen_id;
    logic [4:0] ptr;
    logic so;
  } tx_state_type;

  localparam ctrl_state_type CTRL_RESET = '{
    cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1,
    rstp_s1: 1'b0, rstp_s2: 1'b0, psel_s1: 1'b1, psel_s2: 1'b1,
    par_s1: `PAR_OFF, par_s2: `PAR_OFF,
    ovl_s1: `FAULT_NONE, ovl_s2: `FAULT_NONE, opn_s1: `FAULT_NONE,
    opn_s2: `FAULT_NONE, sgd_s1: `FAULT_NONE, sgd_s2: `FAULT_NONE,
    diag: `DIAG_IDLE, snap: `DIAG_IDLE, frame_id: 1'b0, frame_open: 1'b0,
    latch: `CHAN_OFF, out: `CHAN_OFF, fault_oe: 1'b0, so_oe: 1'b0};

  // overload outranks short to ground, which outranks open load
  function automatic diag_code_type fault_code(input logic ovl, input logic sgd,
                                               input logic opn);
    if (ovl) return `CODE_OVERLOAD;
    else if (sgd) return `CODE_SHORT_GND;
    else if (opn) return `CODE_OPEN;
    else return `CODE_OK;
  endfunction

  // parallel input seen through the polarity select
  function automatic logic par_active(input logic psel, input logic pin);
    return psel ? pin : ~pin;
  endfunction
endpackage

// >>> rtl/link_if.sv
// signals between control domain and the serial clock logic
`timescale 1ns/1ns
interface link_if;
  logic frame_id;
  logic [15:0] snap;
  logic [15:0] rx_word;
  logic [4:0] rx_count;
  logic rx_id;
  modport ctrl(output frame_id, output snap, input rx_word, input rx_count, input rx_id);
  modport rx(input frame_id, output rx_word, output rx_count, output rx_id);
  modport tx(input frame_id, input snap);
endinterface

// >>> rtl/link_receiver.sv
// serial input shifter and pulse counter on falling serial clock
`timescale 1ns/1ns
`include "octal_switch_map.svh"
module link_receiver (
  input wire logic sclk,
  input wire logic si,
  link_if.rx link
);
  octal_switch_pkg::rx_state_type q;
  octal_switch_pkg::rx_state_type d;

  // frame_id only changes while sclk idles, so it is read directly
  always_comb begin
    d = q;
    if (q.seen_id == link.frame_id) begin
      d.word = {q.word[14:0], si};
      if (q.count != `COUNT_MAX) begin
        d.count = q.count + 5'h01;
      end
    end else begin
      // unknown id after power-up also lands here and restarts cleanly
      d.seen_id = link.frame_id;
      d.word = '0;
      d.word[0] = si;
      d.count = 5'h01;
    end
  end

  always_ff @(negedge sclk) begin
    q <= d;
  end

  assign link.rx_word = q.word;
  assign link.rx_count = q.count;
  assign link.rx_id = q.seen_id;
endmodule // link_receiver

// >>> rtl/link_transmitter.sv
// diagnosis shifter driving serial output on rising serial clock
`timescale 1ns/1ns
`include "octal_switch_map.svh"
module link_transmitter (
  input wire logic sclk,
  link_if.tx link,
  output logic so
);
  octal_switch_pkg::tx_state_type q;
  octal_switch_pkg::tx_state_type d;

  always_comb begin
    d = q;
    if (q.seen_id == link.frame_id) begin
      if (q.ptr < `FRAME_BITS) begin
        d.so = link.snap[~q.ptr[3:0]];
        d.ptr = q.ptr + 5'h01;
      end else begin
        d.so = 1'b1;
      end
    end else begin
      d.seen_id = link.frame_id;
      d.so = link.snap[`CTRL_MSB];
      d.ptr = 5'h01;
    end
  end

  always_ff @(posedge sclk) begin
    q <= d;
  end

  assign so = q.so;
endmodule // link_transmitter

// >>> rtl/octal_switch_spi_diag.sv
// serial control and fault diagnosis of an eight-channel low-side switch
`timescale 1ns/1ns
`include "octal_switch_map.svh"
module octal_switch_spi_diag (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic reset_pin_n,
  input wire logic parallel_polarity_select,
  input wire logic [3:0] par_in,
  input wire logic [7:0] fault_overload,
  input wire logic [7:0] fault_open_load,
  input wire logic [7:0] fault_short_gnd,
  output logic so_o,
  output logic so_oe,
  output logic fault_n_o,
  output logic fault_n_oe,
  output logic [7:0] chan_on
);
  octal_switch_pkg::ctrl_state_type q;
  octal_switch_pkg::ctrl_state_type d;

  link_if link ();

  logic cs_rise;
  logic cs_fall;
  logic rst_active;
  logic frame_ok;
  logic ctrl_update;
  logic [7:0] gate;

  // edges of the synchronised chip select (cs_s1 only feeds cs_s2)
  assign cs_rise = q.cs_s2 & ~q.cs_prev;
  assign cs_fall = ~q.cs_s2 & q.cs_prev;
  assign rst_active = ~q.rstp_s2;

  // sclk must be idle at select rise, so the link words are stable here
  // exactly sixteen pulses
  assign frame_ok = q.frame_open && (link.rx_id == q.frame_id) &&
                    (link.rx_count == `FRAME_BITS);
  assign ctrl_update = link.rx_word[`CTRL_MSB:`CTRL_LSB] != `CTRL_DIAG_ONLY;

  always_comb begin
    gate = '1;
    for (int ch = 0; ch < `PAR_CHANNELS; ch++) begin
      gate[ch] = octal_switch_pkg::par_active(q.psel_s2, q.par_s2[ch]);
    end
  end

  always_comb begin
    octal_switch_pkg::diag_code_type code;
    code = `CODE_OK;
    d = q;
    if (ce) begin
      d.cs_s1 = cs_n;
      d.cs_s2 = q.cs_s1;
      d.cs_prev = q.cs_s2;
      d.rstp_s1 = reset_pin_n;
      d.rstp_s2 = q.rstp_s1;
      d.psel_s1 = parallel_polarity_select;
      d.psel_s2 = q.psel_s1;
      d.par_s1 = par_in;
      d.par_s2 = q.par_s1;
      d.ovl_s1 = fault_overload;
      d.ovl_s2 = q.ovl_s1;
      d.opn_s1 = fault_open_load;
      d.opn_s2 = q.opn_s1;
      d.sgd_s1 = fault_short_gnd;
      d.sgd_s2 = q.sgd_s1;

      // detectors are levels: a fault still present keeps its code,
      // so a clear in the same cycle never hides a live fault
      for (int ch = 0; ch < `CHANNELS; ch++) begin
        code = octal_switch_pkg::fault_code(q.ovl_s2[ch], q.sgd_s2[ch], q.opn_s2[ch]);
        if (code != `CODE_OK) begin
          d.diag[2 * ch +: 2] = code;
        end else if (cs_rise) begin
          d.diag[2 * ch +: 2] = `CODE_OK;
        end
      end

      d.fault_oe = d.diag != `DIAG_IDLE;

      d.so_oe = ~q.cs_s2;

      if (cs_fall) begin
        d.snap = q.diag;
        // new id restarts both shifters on their first edge
        d.frame_id = ~q.frame_id;
        d.frame_open = ~rst_active;
      end

      if (cs_rise) begin
        d.frame_open = 1'b0;
        if (frame_ok && ctrl_update) begin
          d.latch = link.rx_word[`DATA_MSB:`DATA_LSB];
        end
      end

      d.out = q.latch & gate;

      if (rst_active) begin
        d.frame_open = 1'b0;
        d.latch = `CHAN_OFF;
        d.out = `CHAN_OFF;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= octal_switch_pkg::CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  assign link.frame_id = q.frame_id;
  assign link.snap = q.snap;

  link_receiver u_rx (
    .sclk(sclk),
    .si(si),
    .link(link.rx)
  );

  link_transmitter u_tx (
    .sclk(sclk),
    .link(link.tx),
    .so(so_o)
  );

  // open drain: only ever pulls low
  assign fault_n_o = 1'b0;
  assign fault_n_oe = q.fault_oe;
  assign so_oe = q.so_oe;
  assign chan_on = q.out;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_accept;
    ce && cs_rise && frame_ok && ctrl_update && q.rstp_s2;
  endsequence

  sequence s_diag_only;
    ce && cs_rise && !ctrl_update && q.rstp_s2;
  endsequence

  sequence s_short_len;
    ce && cs_rise && !frame_ok && q.rstp_s2;
  endsequence

  property p_reset_off;
    ce && rst_active |=> (chan_on == `CHAN_OFF) && (q.latch == `CHAN_OFF);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("outputs on under reset pin");

  property p_fault_flag;
    ce && (|q.ovl_s2 || |q.sgd_s2 || |q.opn_s2) |=> fault_n_oe;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault flag not asserted");

  property p_overload_code;
    ce && q.ovl_s2[7] |=> q.diag[15:14] == `CODE_OVERLOAD;
  endproperty
  a_overload_code: assert property (p_overload_code) else $error("overload code wrong");

  property p_open_code;
    ce && q.opn_s2[0] && !q.ovl_s2[0] && !q.sgd_s2[0] |=> q.diag[1:0] == `CODE_OPEN;
  endproperty
  a_open_code: assert property (p_open_code) else $error("open load code wrong");

  property p_short_code;
    ce && q.sgd_s2[3] && !q.ovl_s2[3] |=> q.diag[7:6] == `CODE_SHORT_GND;
  endproperty
  a_short_code: assert property (p_short_code) else $error("short to ground code wrong");

  property p_clear;
    ce && cs_rise && !(|q.ovl_s2) && !(|q.sgd_s2) && !(|q.opn_s2)
      |=> (q.diag == `DIAG_IDLE) && !fault_n_oe;
  endproperty
  a_clear: assert property (p_clear) else $error("diagnosis not cleared");

  property p_float;
    ce && q.cs_s2 |=> !so_oe;
  endproperty
  a_float: assert property (p_float) else $error("serial output driven while deselected");

  property p_snapshot;
    ce && cs_fall |=> q.snap == $past(q.diag);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot missed");

  property p_accept;
    s_accept ##1 (ce && q.rstp_s2) |=> chan_on[7:4] == $past(link.rx_word[7:4], 2);
  endproperty
  a_accept: assert property (p_accept) else $error("frame data not applied");

  property p_diag_only;
    s_diag_only |=> $stable(q.latch);
  endproperty
  a_diag_only: assert property (p_diag_only) else $error("zero control changed outputs");

  property p_short_len;
    s_short_len |=> $stable(q.latch);
  endproperty
  a_short_len: assert property (p_short_len) else $error("bad length frame accepted");

  property p_par_gate;
    ce && q.rstp_s2 && !gate[0] |=> !chan_on[0];
  endproperty
  a_par_gate: assert property (p_par_gate) else $error("channel on without parallel input");

  property p_drive;
    ce && !q.cs_s2 |=> so_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("serial output not driven");

  property p_ok_code;
    ce && cs_rise && !q.ovl_s2[5] && !q.sgd_s2[5] && !q.opn_s2[5]
      |=> q.diag[11:10] == `CODE_OK;
  endproperty
  a_ok_code: assert property (p_ok_code) else $error("healthy channel code wrong");

  property p_overwrite;
    ce && q.opn_s2[6] && !q.ovl_s2[6] && !q.sgd_s2[6] |=> q.diag[13:12] == `CODE_OPEN;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("new fault not latched");

  property p_accept_low;
    s_accept ##1 (ce && q.rstp_s2)
      |=> chan_on[3:0] == ($past(link.rx_word[3:0], 2) & $past(gate[3:0]));
  endproperty
  a_accept_low: assert property (p_accept_low) else $error("low channels not applied");

  property p_discard;
    ce && rst_active |=> !q.frame_open;
  endproperty
  a_discard: assert property (p_discard) else $error("frame open under reset pin");

  property p_flag_release;
    ce && (q.diag == `DIAG_IDLE) && !(|q.ovl_s2) && !(|q.sgd_s2) && !(|q.opn_s2)
      |=> !fault_n_oe;
  endproperty
  a_flag_release: assert property (p_flag_release) else $error("fault flag without fault");

  property p_new_frame;
    ce && cs_fall |=> q.frame_id != $past(q.frame_id);
  endproperty
  a_new_frame: assert property (p_new_frame) else $error("frame id not toggled");

  property p_hold_latch;
    ce && !cs_rise && q.rstp_s2 |=> $stable(q.latch);
  endproperty
  a_hold_latch: assert property (p_hold_latch) else $error("latch changed outside select rise");

  property p_snap_hold;
    ce && !cs_fall |=> $stable(q.snap);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed in frame");

  property p_gate_high;
    ce && q.rstp_s2 && q.psel_s2 && q.par_s2[1] && q.latch[1] |=> chan_on[1];
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("active-high gating wrong");
endmodule // octal_switch_spi_diag

// >>> tb/spi_master_model.sv
// serial master model that sends frames on its own link clock
`timescale 1ns/1ns
module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so_o
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  task automatic xfer(input logic [15:0] word, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    // select-to-clock gap covers the slow clock-domain sync
    #200;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      si = word[15 - i];
      #8;
      sclk = 1'b0;
      rx = {rx[14:0], so_o};
      #7;
    end
    #15;
    cs_n = 1'b1;
    // released input must not keep its last value
    si = ~si;
    #400;
  endtask
endmodule // spi_master_model

// >>> tb/octal_switch_spi_diag_tb_top.sv
// self-checking bench of the octal switch serial control and diagnosis
`timescale 1ns/1ns
module octal_switch_spi_diag_tb_top;
  logic clk, reset, ce, reset_pin_n, pol, sclk, cs_n, si, so_o, so_oe, so_line;
  logic fault_n_o, fault_n_oe;
  logic [3:0] par;
  logic [7:0] ovl, opn, sgd, chan_on;
  logic [15:0] rx;
  int checks = 0;
  int num_errors = 0;
  logic [15:0] words [4] = '{16'hFFA5, 16'h00FF, 16'h813C, 16'hFF00};
  int lens [4] = '{16, 16, 16, 15};
  logic [7:0] exp_on [4] = '{8'hA5, 8'hA5, 8'h3C, 8'h3C};

  octal_switch_spi_diag i_dut (
    .clk(clk), .reset(reset), .ce(ce), .sclk(sclk), .cs_n(cs_n), .si(si),
    .reset_pin_n(reset_pin_n), .parallel_polarity_select(pol), .par_in(par),
    .fault_overload(ovl), .fault_open_load(opn), .fault_short_gnd(sgd),
    .so_o(so_o), .so_oe(so_oe), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
    .chan_on(chan_on)
  );

  // undriven line shows the inverse, so a late enable corrupts the read
  assign so_line = so_oe ? so_o : ~so_o;

  spi_master_model i_master (.sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_line));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask

  task automatic frame(input logic [15:0] w, input int n);
    fork
      i_master.xfer(w, n, rx);
      begin
        #300;
        chk_flag(so_oe, 1'b1, "so drive in frame");
      end
    join
    chk_flag(so_oe, 1'b0, "so float when idle");
    // realign later stimulus to just after a clock edge
    wait_clk(1);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    reset_pin_n = 1'b1;
    pol = 1'b1;
    par = 4'hF;
    ovl = 8'h00;
    opn = 8'h00;
    sgd = 8'h00;
    wait_clk(4);
    reset = 1'b0;
    wait_clk(4);
    chk_word({8'h00, chan_on}, 16'h0000, "outputs after reset");
    chk_flag(fault_n_oe, 1'b0, "fault flag after reset");
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      frame(words[i], lens[i]);
      chk_word({8'h00, chan_on}, {8'h00, exp_on[i]}, "outputs after frame");
    end
    $display("test control byte done");

    par = 4'h5;
    wait_clk(5);
    frame(16'hFFFF, 16);
    chk_word({8'h00, chan_on}, 16'h00F5, "parallel gating high");
    pol = 1'b0;
    wait_clk(5);
    frame(16'hFFFF, 16);
    chk_word({8'h00, chan_on}, 16'h00FA, "parallel gating low");
    ce = 1'b0;
    par = 4'hF;
    wait_clk(6);
    chk_word({8'h00, chan_on}, 16'h00FA, "frozen while disabled");
    ce = 1'b1;
    wait_clk(6);
    chk_word({8'h00, chan_on}, 16'h00F0, "gating after enable");
    $display("test parallel done");

    // overload ch8, short ch4, open ch1
    ovl = 8'h80;
    opn = 8'h01;
    sgd = 8'h08;
    wait_clk(6);
    chk_flag(fault_n_oe, 1'b1, "fault flag raised");
    chk_flag(fault_n_o, 1'b0, "fault line pulled low");
    frame(16'h0000, 16);
    chk_word(rx, 16'hBF3D, "diagnosis codes");
    ovl = 8'h00;
    opn = 8'h00;
    sgd = 8'h00;
    wait_clk(6);
    frame(16'h0000, 16);
    chk_word(rx, 16'hBF3D, "latched after fault gone");
    frame(16'h0000, 16);
    chk_word(rx, 16'hFFFF, "cleared by select rise");
    chk_flag(fault_n_oe, 1'b0, "fault flag released");
    $display("test diagnosis done");

    reset_pin_n = 1'b0;
    wait_clk(5);
    chk_word({8'h00, chan_on}, 16'h0000, "outputs off by reset pin");
    frame(16'hFFFF, 16);
    chk_word({8'h00, chan_on}, 16'h0000, "frame refused under reset pin");
    reset_pin_n = 1'b1;
    wait_clk(5);
    chk_word({8'h00, chan_on}, 16'h0000, "latch cleared by reset pin");
    $display("test reset pin done");
    final_report();
  end
endmodule // octal_switch_spi_diag_tb_top
